/* File: design/calse_pkg.sv */
// =====================================================
// Calendar set and elapsed-time constants and types
`default_nettype none

package calse_pkg;

   // =====================================================
   // Field layout, one BCD byte per field; binary copy with seven bits per field
   typedef struct packed {
      logic [7:0] year;
      logic [7:0] month;
      logic [7:0] day;
      logic [7:0] hour;
      logic [7:0] minute;
      logic [7:0] second;
   } calse_time_t;

   typedef struct packed {
      logic [6:0] year;
      logic [6:0] month;
      logic [6:0] day;
      logic [6:0] hour;
      logic [6:0] minute;
      logic [6:0] second;
   } calse_bin_t;

   // =====================================================
   // Ranges and borrow figures
   localparam logic [6:0] SEC_MAX      = 7'h3b;
   localparam logic [6:0] MIN_MAX      = 7'h3b;
   localparam logic [6:0] HOUR_MAX     = 7'h17;
   localparam logic [6:0] MONTH_MAX    = 7'h0c;
   localparam logic [6:0] YEAR_MAX     = 7'h63;
   localparam int         SECS_PER_MIN = 60;
   localparam int         MINS_PER_HR  = 60;
   localparam int         HRS_PER_DAY  = 24;
   localparam int         DAYS_PER_YR  = 365;
   localparam int         DAYS_PER_MON = 30;
   localparam int         DOW_COUNT    = 7;
   localparam int         DOW_EPOCH    = 6;

   // =====================================================
   // Reset values: year 00, January 1st, 00:00:00, Saturday
   localparam calse_bin_t RST_TIME = '{7'h00, 7'h01, 7'h01, 7'h00, 7'h00, 7'h00};
   localparam logic [2:0] RST_DOW  = 3'h6;

   function automatic logic is_leap(input logic [6:0] y);
      return (y[1:0] == 2'h0);
   endfunction

   function automatic logic [6:0] month_days(input logic [6:0] y, input logic [6:0] m);
      unique case (m)
         7'h02:                      return is_leap(y) ? 7'h1d : 7'h1c;
         7'h04, 7'h06, 7'h09, 7'h0b: return 7'h1e;
         default:                    return 7'h1f;
      endcase
   endfunction

   // Days in the year before the first of month m
   function automatic logic [8:0] days_before(input logic [6:0] y, input logic [6:0] m);
      logic [8:0] d;
      d = 9'h000;
      for (int i = 1; i < 12; i++)
         if (7'(i) < m)
            d = d + 9'(month_days(y, 7'(i)));
      return d;
   endfunction

   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      return {4'(v / 7'h0a), 4'(v % 7'h0a)};
   endfunction

endpackage

`default_nettype wire

/* File: design/calse_check.sv */
`timescale 1ns/10ps
`default_nettype none

module calse_check
(
   // Operand table
   input  wire calse_pkg::calse_time_t operand,
   // Checked result
   output logic                        valid,
   output calse_pkg::calse_bin_t       bin
);

   logic [5:0] digit_ok;
   logic [5:0] range_ok;
   logic [7:0] field [6];

   assign field[0] = operand.year;
   assign field[1] = operand.month;
   assign field[2] = operand.day;
   assign field[3] = operand.hour;
   assign field[4] = operand.minute;
   assign field[5] = operand.second;

   // =====================================================
   // Per-field BCD digit check
   genvar g;
   generate
      for (g = 0; g < 6; g++)
      begin : g_digit
         assign digit_ok[g] = (field[g][7:4] <= 4'h9) && (field[g][3:0] <= 4'h9); // R10
      end
   endgenerate

   // =====================================================
   // Conversion and calendar ranges
   always_comb
   begin
      bin.year   = 7'(field[0][7:4] * 4'ha) + 7'(field[0][3:0]); // R9
      bin.month  = 7'(field[1][7:4] * 4'ha) + 7'(field[1][3:0]);
      bin.day    = 7'(field[2][7:4] * 4'ha) + 7'(field[2][3:0]);
      bin.hour   = 7'(field[3][7:4] * 4'ha) + 7'(field[3][3:0]);
      bin.minute = 7'(field[4][7:4] * 4'ha) + 7'(field[4][3:0]);
      bin.second = 7'(field[5][7:4] * 4'ha) + 7'(field[5][3:0]);
      range_ok[0] = bin.year <= calse_pkg::YEAR_MAX;
      range_ok[1] = (bin.month != 7'h00) && (bin.month <= calse_pkg::MONTH_MAX); // R10
      range_ok[2] = (bin.day != 7'h00) // R10
                    && (bin.day <= calse_pkg::month_days(bin.year, bin.month));
      range_ok[3] = bin.hour <= calse_pkg::HOUR_MAX; // R10
      range_ok[4] = bin.minute <= calse_pkg::MIN_MAX; // R10
      range_ok[5] = bin.second <= calse_pkg::SEC_MAX; // R10
      valid = (&digit_ok) && (&range_ok);
   end

endmodule

`default_nettype wire

/* File: design/calse_top.sv */
// What this block does
// (R1) While load input is high, calendar takes the six operand fields.
// (R2) Invalid operand data: no set or subtract, error output high.
// (R3) Error output low after valid operation and while input is low.
// (R4) Day of week is computed on load, never taken from operands.
// (R5) While difference input is high, operand is subtracted from calendar.
// (R6) Difference written as year, month, day, hour, minute, second fields.
// (R7) Requester never gives a subtrahend later than the current calendar.
// (R8) Borrowing treats a year as 365 days, a month as 30.
// (R9) Fields ordered year to second, two BCD digits each in low byte.
// (R10) Non-BCD digits or out-of-range calendar fields are invalid.
`timescale 1ns/10ps
`default_nettype none

module calse_top
(
   // Clock, reset, enable
   input  wire logic                   clk_sys,
   input  wire logic                   rst_n,
   input  wire logic                   clk_en,
   // One-second advance pulse
   input  wire logic                   sec_tick,
   // Set calendar request
   input  wire logic                   calendar_load_instruction,
   input  wire calse_pkg::calse_time_t load_operand,
   output logic                        load_error,
   // Elapsed time request
   input  wire logic                   calendar_difference_instruction,
   input  wire calse_pkg::calse_time_t diff_operand,
   output logic                        diff_error,
   output calse_pkg::calse_time_t      diff_result,
   // Current calendar
   output calse_pkg::calse_time_t      now,
   output logic [2:0]                  day_of_week
);

   calse_pkg::calse_bin_t  now_bin;
   calse_pkg::calse_bin_t  next_now_bin;
   calse_pkg::calse_time_t next_now;
   calse_pkg::calse_time_t next_diff_result;
   calse_pkg::calse_time_t diff_calc;
   calse_pkg::calse_bin_t  load_bin;
   calse_pkg::calse_bin_t  sub_bin;
   logic [2:0]             next_day_of_week;
   logic [2:0]             load_dow;
   logic                   next_load_error;
   logic                   next_diff_error;
   logic                   load_ok;
   logic                   sub_ok;
   logic                   sub_future;
   logic                   diff_ok;

   // =====================================================
   // Operand checks
   calse_check u_load_check
   (
      .operand (load_operand),
      .valid   (load_ok),
      .bin     (load_bin)
   );

   calse_check u_diff_check
   (
      .operand (diff_operand),
      .valid   (sub_ok),
      .bin     (sub_bin)
   );

   // =====================================================
   // Day of week of a loaded date, counted from year 00
   always_comb
   begin
      int days;
      days = int'(load_bin.year) * calse_pkg::DAYS_PER_YR + (int'(load_bin.year) + 3) / 4
           + int'(calse_pkg::days_before(load_bin.year, load_bin.month))
           + int'(load_bin.day) - 1;
      load_dow = 3'((days + calse_pkg::DOW_EPOCH) % calse_pkg::DOW_COUNT); // R4
   end

   // =====================================================
   // Elapsed time, fixed-length years and months
   always_comb
   begin
      int ds;
      int dm;
      int dh;
      int dd;
      int rem;
      rem = 0;
      ds = int'(now_bin.second) - int'(sub_bin.second);
      dm = int'(now_bin.minute) - int'(sub_bin.minute);
      dh = int'(now_bin.hour) - int'(sub_bin.hour);
      dd = int'(now_bin.year) * calse_pkg::DAYS_PER_YR
         + int'(calse_pkg::days_before(now_bin.year, now_bin.month)) + int'(now_bin.day)
         - int'(sub_bin.year) * calse_pkg::DAYS_PER_YR
         - int'(calse_pkg::days_before(sub_bin.year, sub_bin.month)) - int'(sub_bin.day);
      if (ds < 0)
      begin
         ds = ds + calse_pkg::SECS_PER_MIN;
         dm = dm - 1;
      end
      if (dm < 0)
      begin
         dm = dm + calse_pkg::MINS_PER_HR;
         dh = dh - 1;
      end
      if (dh < 0)
      begin
         dh = dh + calse_pkg::HRS_PER_DAY;
         dd = dd - 1;
      end
      sub_future = dd < 0; // R7
      if (sub_future)
         dd = 0;
      rem = dd % calse_pkg::DAYS_PER_YR; // R8
      diff_calc.year   = calse_pkg::to_bcd(7'(dd / calse_pkg::DAYS_PER_YR)); // R6
      diff_calc.month  = calse_pkg::to_bcd(7'(rem / calse_pkg::DAYS_PER_MON)); // R8
      diff_calc.day    = calse_pkg::to_bcd(7'(rem % calse_pkg::DAYS_PER_MON));
      diff_calc.hour   = calse_pkg::to_bcd(7'(dh));
      diff_calc.minute = calse_pkg::to_bcd(7'(dm));
      diff_calc.second = calse_pkg::to_bcd(7'(ds));
   end

   assign diff_ok = sub_ok && !sub_future;

   // =====================================================
   // Next state: load, advance, subtract
   always_comb
   begin
      next_now_bin     = now_bin;
      next_day_of_week = day_of_week;
      next_load_error  = 1'b0; // R3
      next_diff_error  = 1'b0; // R3
      next_diff_result = diff_result;
      if (calendar_load_instruction)
      begin
         if (load_ok)
         begin
            next_now_bin     = load_bin; // R1
            next_day_of_week = load_dow; // R4
         end
         else
            next_load_error = 1'b1; // R2
      end
      else if (sec_tick)
      begin
         next_now_bin.second = now_bin.second + 7'h01;
         if (now_bin.second == calse_pkg::SEC_MAX)
         begin
            next_now_bin.second = 7'h00;
            next_now_bin.minute = now_bin.minute + 7'h01;
            if (now_bin.minute == calse_pkg::MIN_MAX)
            begin
               next_now_bin.minute = 7'h00;
               next_now_bin.hour   = now_bin.hour + 7'h01;
               if (now_bin.hour == calse_pkg::HOUR_MAX)
               begin
                  next_now_bin.hour = 7'h00;
                  next_now_bin.day  = now_bin.day + 7'h01;
                  next_day_of_week  = (day_of_week == 3'h6) ? 3'h0 : day_of_week + 3'h1;
                  if (now_bin.day == calse_pkg::month_days(now_bin.year, now_bin.month))
                  begin
                     next_now_bin.day   = 7'h01;
                     next_now_bin.month = now_bin.month + 7'h01;
                     if (now_bin.month == calse_pkg::MONTH_MAX)
                     begin
                        next_now_bin.month = 7'h01;
                        next_now_bin.year  = (now_bin.year == calse_pkg::YEAR_MAX) ?
                                             7'h00 : now_bin.year + 7'h01;
                     end
                  end
               end
            end
         end
      end
      if (calendar_difference_instruction)
      begin
         if (diff_ok)
            next_diff_result = diff_calc; // R5
         else
            next_diff_error = 1'b1; // R2
      end
      next_now.year   = calse_pkg::to_bcd(next_now_bin.year); // R9
      next_now.month  = calse_pkg::to_bcd(next_now_bin.month);
      next_now.day    = calse_pkg::to_bcd(next_now_bin.day);
      next_now.hour   = calse_pkg::to_bcd(next_now_bin.hour);
      next_now.minute = calse_pkg::to_bcd(next_now_bin.minute);
      next_now.second = calse_pkg::to_bcd(next_now_bin.second);
   end

   // =====================================================
   // State registers
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         now_bin     <= calse_pkg::RST_TIME;
         now         <= '{8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
         day_of_week <= calse_pkg::RST_DOW;
         load_error  <= 1'b0;
         diff_error  <= 1'b0;
         diff_result <= '0;
      end
      else if (clk_en)
      begin
         now_bin     <= next_now_bin;
         now         <= next_now;
         day_of_week <= next_day_of_week;
         load_error  <= next_load_error;
         diff_error  <= next_diff_error;
         diff_result <= next_diff_result;
      end
   end

   // =====================================================
   // Assertions
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence s_good_load;
      clk_en && calendar_load_instruction && load_ok;
   endsequence

   sequence s_bad_load;
      clk_en && calendar_load_instruction && !load_ok;
   endsequence

   sequence s_good_diff;
      clk_en && calendar_difference_instruction && diff_ok;
   endsequence

   sequence s_bad_diff;
      clk_en && calendar_difference_instruction && !diff_ok;
   endsequence

   a_load_sets_time: assert property (s_good_load |=> // R1
      now == $past(load_operand) && !load_error)
      else $error("calendar not loaded from operand");
   a_load_bad_flag: assert property (s_bad_load |=> load_error && $stable(now)) // R2
      else $error("invalid load not refused");
   a_load_idle_low: assert property (clk_en && !calendar_load_instruction |=> !load_error) // R3
      else $error("load error high while idle");
   a_load_weekday: assert property (s_good_load |=> day_of_week == $past(load_dow)) // R4
      else $error("weekday not computed on load");
   a_diff_result: assert property (s_good_diff |=> // R5
      diff_result == $past(diff_calc) && !diff_error)
      else $error("difference not stored");
   a_diff_bad_hold: assert property (s_bad_diff |=> diff_error && $stable(diff_result)) // R2
      else $error("invalid subtract not refused");
   a_diff_idle_low: assert property (clk_en && !calendar_difference_instruction |=> // R3
      !diff_error)
      else $error("difference error high while idle");
   a_diff_borrow_range: assert property (diff_result.month <= 8'h12 && // R8
      diff_result.day <= 8'h29)
      else $error("difference month or day out of fixed range");
   a_freeze_state: assert property (!clk_en |=> $stable(now) && $stable(diff_result)) // clock enable low holds now and diff_result
      else $error("state moved while clock enable low");

endmodule

`default_nettype wire

/* File: test/calse_ladder.sv */
`timescale 1ns/10ps
`default_nettype none

module calse_ladder
(
   // Clock
   input  wire logic              clk_sys,
   // Requests toward the block
   output logic                   load_req,
   output calse_pkg::calse_time_t load_op,
   output logic                   diff_req,
   output calse_pkg::calse_time_t diff_op
);
   initial
   begin
      load_req = 1'b0;
      diff_req = 1'b0;
      load_op  = '0;
      diff_op  = '0;
   end

   // =====================================================
   // One scan with the request high, stale operands inverted after
   // Caller gives subtrahends no later than the calendar unless a refusal is wanted
   task automatic run(input logic kind, input calse_pkg::calse_time_t op);
      @(posedge clk_sys);
      if (kind)
      begin
         diff_req <= 1'b1;
         diff_op  <= op;
      end
      else
      begin
         load_req <= 1'b1;
         load_op  <= op;
      end
      @(posedge clk_sys);
      load_req <= 1'b0;
      diff_req <= 1'b0;
      load_op  <= ~op;
      diff_op  <= ~op;
   endtask
endmodule

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
   typedef struct {logic kind; logic err; calse_pkg::calse_time_t val;
                   logic [2:0] dow;} calse_note_t;

   logic                   clk_sys;
   logic                   rst_n;
   logic                   clk_en;
   logic                   sec_tick;
   logic                   load_req;
   logic                   diff_req;
   calse_pkg::calse_time_t load_op;
   calse_pkg::calse_time_t diff_op;
   logic                   load_error;
   logic                   diff_error;
   calse_pkg::calse_time_t diff_result;
   calse_pkg::calse_time_t now;
   logic [2:0]             day_of_week;
   int                     error_cnt;
   int                     comparisons;
   calse_note_t            notes[$];
   calse_note_t            note;
   logic [1:0]             took;
   calse_pkg::calse_time_t cur;
   calse_pkg::calse_time_t last;
   int                     y;
   int                     mo;
   int                     d;
   calse_pkg::calse_time_t bad[8] = '{48'h01_02_29_00_00_00, 48'h04_13_01_00_00_00,
      48'h04_00_01_00_00_00, 48'h04_04_31_00_00_00, 48'h04_01_01_24_00_00,
      48'h04_01_01_00_60_00, 48'h04_01_01_00_00_1a, 48'ha0_01_01_00_00_00};

   calse_top dut
   (
      .clk_sys                         (clk_sys),
      .rst_n                           (rst_n),
      .clk_en                          (clk_en),
      .sec_tick                        (sec_tick),
      .calendar_load_instruction       (load_req),
      .load_operand                    (load_op),
      .load_error                      (load_error),
      .calendar_difference_instruction (diff_req),
      .diff_operand                    (diff_op),
      .diff_error                      (diff_error),
      .diff_result                     (diff_result),
      .now                             (now),
      .day_of_week                     (day_of_week)
   );

   calse_ladder ladder
   (
      .clk_sys  (clk_sys),
      .load_req (load_req),
      .load_op  (load_op),
      .diff_req (diff_req),
      .diff_op  (diff_op)
   );

   always #25 clk_sys = ~clk_sys;

   // =====================================================
   // Helpers
   function automatic logic [7:0] bcd(input int v);
      return {4'(v / 10), 4'(v % 10)};
   endfunction

   function automatic calse_pkg::calse_time_t stamp(input int a, b, c, h, m, s);
      return {bcd(a), bcd(b), bcd(c), bcd(h), bcd(m), bcd(s)};
   endfunction

   function automatic logic [2:0] wday(input int a, b, c);
      int days;
      int mlen[12] = '{31, 28, 31, 30, 31, 30, 31, 31, 30, 31, 30, 31};
      days = a * 365 + (a + 3) / 4 + c - 1;
      for (int i = 1; i < b; i++)
         days += (i == 2 && a % 4 == 0) ? 29 : mlen[i - 1];
      return 3'((6 + days) % 7);
   endfunction

   task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic req(input logic kind, input logic err, input calse_pkg::calse_time_t op,
                      input calse_pkg::calse_time_t val, input logic [2:0] dow);
      notes.push_back('{kind, err, val, dow});
      ladder.run(kind, op);
   endtask

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // =====================================================
   // Result monitor
   always @(posedge clk_sys)
      took <= {diff_req, load_req} & {2{clk_en & rst_n}};

   always @(negedge clk_sys)
      if (took != 2'h0 && notes.size() > 0)
      begin
         note = notes.pop_front();
         if (note.kind)
         begin
            check("diff_error", {47'h0, diff_error}, {47'h0, note.err});
            check("diff_result", diff_result, note.val);
         end
         else
         begin
            check("load_error", {47'h0, load_error}, {47'h0, note.err});
            check("now", now, note.val);
            if (!note.err)
               check("day_of_week", {45'h0, day_of_week}, {45'h0, note.dow});
         end
      end

   initial
   begin
      #(50 * 3000);
      error_cnt++;
      conclude();
   end

   // =====================================================
   // Tests
   initial
   begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      clk_en = 1'b1;
      sec_tick = 1'b0;
      error_cnt = 0;
      comparisons = 0;
      took = 2'h0;
      void'($urandom(97));
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(negedge clk_sys);
      check("now", now, 48'h00_01_01_00_00_00);
      check("diff_result", diff_result, 48'h0);
      $display("test reset done");
      cur = stamp(98, 1, 15, 17, 0, 0);
      req(1'b0, 1'b0, cur, cur, wday(98, 1, 15));
      last = 48'h00_03_07_01_30_00;
      req(1'b1, 1'b0, stamp(97, 10, 10, 15, 30, 0), last, 3'h0);
      req(1'b1, 1'b1, stamp(98, 1, 15, 17, 0, 1), last, 3'h0);
      req(1'b1, 1'b1, 48'h97_10_10_15_3a_00, last, 3'h0);
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("diff_error", {47'h0, diff_error}, 48'h0);
      $display("test difference done");
      foreach (bad[i])
         req(1'b0, 1'b1, bad[i], cur, 3'h0);
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("load_error", {47'h0, load_error}, 48'h0);
      $display("test invalid load done");
      cur = stamp(4, 2, 29, 23, 59, 59);
      req(1'b0, 1'b0, cur, cur, wday(4, 2, 29));
      @(posedge clk_sys);
      sec_tick <= 1'b1;
      @(posedge clk_sys);
      sec_tick <= 1'b0;
      @(negedge clk_sys);
      cur = stamp(4, 3, 1, 0, 0, 0);
      check("now", now, cur);
      check("day_of_week", {45'h0, day_of_week}, {45'h0, wday(4, 3, 1)});
      @(posedge clk_sys);
      clk_en <= 1'b0;
      ladder.run(1'b0, stamp(50, 5, 5, 5, 5, 5));
      @(posedge clk_sys);
      clk_en <= 1'b1;
      @(negedge clk_sys);
      check("now", now, cur);
      $display("test tick and freeze done");
      repeat (20)
      begin
         y = $urandom % 100;
         mo = 1 + $urandom % 12;
         d = 1 + $urandom % 28;
         cur = stamp(y, mo, d, $urandom % 24, $urandom % 60, $urandom % 60);
         req(1'b0, 1'b0, cur, cur, wday(y, mo, d));
         req(1'b1, 1'b0, cur, 48'h0, 3'h0);
      end
      $display("test random done");
      repeat (2) @(posedge clk_sys);
      conclude();
   end
endmodule

`default_nettype wire
